// ### host_irq_link.sv
// host interrupt exchange and two-wire slave front end of the serial slave port
// Behaviour
// - eight host interrupts merged into one line
// - host writes enable byte at 0x78
// - ones at 0x7A clear, at 0x7B set
// - 0x79 returns state, CPU reads too
// - CPU sees enables read-only, reads state
// - CPU sets bits singly, clears all
// - underflow sets bit 7, read error 6
// - line high when any enabled bit set
// - pad 4 carries line when selected
// - any host write 0x78-0x7B flags CPU
// - direct space transfers set completion flags
// - FIFO offset transfers set completion flags
// - burst into FIFO sets both flags
// - 128 offsets, top eight are hardware
// - configurable address, 7 or 10 bit
// - slave only, up to 1 MHz
// - START detect; restart acts as STOP+START
// - STOP detect ends transfer
// - data changes only while clock low
// - acknowledge each received byte low
// - release line after master's final NAK
// - unlimited bytes per transfer
// - empty FIFO read raises underflow
// - read during FIFO update raises error
module host_irq_link
   import host_irq_link_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   output logic O_SDA,
   output logic O_SDA_OE,
   input wire link_cfg_t I_CFG,
   input wire cpu_host_irq_control_t I_CPU_CTRL,
   input wire cpu_flag_status_t I_CPU_FLAG_CLR,
   input wire fifo_side_t I_FIFO,
   input wire logic [7:0] I_RAM_RDATA,
   output ram_req_t O_RAM,
   output logic O_FIFO_POP,
   output logic O_HOST_IRQ_LINE,
   output logic O_PAD4,
   output logic O_PAD4_OE,
   output logic [7:0] O_IRQ_ENABLE,
   output logic [7:0] O_IRQ_STATE,
   output cpu_flag_status_t O_CPU_FLAGS
);

   function automatic logic [6:0] next_ptr(input logic [6:0] p);
      return (p == OFF_FIFO) ? p : p + 7'h1;
   endfunction

   function automatic logic is_irq_off(input logic [6:0] o);
      return (o >= OFF_IRQ_ENABLE) && (o <= OFF_IRQ_SET);
   endfunction

   logic scl_s, sda_s, scl_d, sda_d;
   logic scl_rise, scl_fall, start_det, stop_det, byte_done, load_tx;
   link_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [6:0] ptr_reg;
   logic rw_reg, first_reg, long_hit_reg, sda_oe_reg, end_reg;
   logic hw_we_reg, hr_reg;
   logic [6:0] hw_off_reg, hr_off_reg;
   logic [7:0] hw_data_reg, rd_byte;
   logic und_reg, host_read_error_bit_reg, pop_reg;
   logic [7:0] irq_en_reg, irq_state_reg, set_v, clr_v;
   logic line_reg, pad4_reg, pad4_oe_reg;
   logic t_dw_reg, t_dr_reg, t_fw_reg, t_fr_reg;
   logic [3:0] done_reg;
   cpu_flag_status_t flags_reg, flag_set;
   ram_req_t ram_reg;

   // bus lines cross into the system clock through three stages
   link_pin_sync #(.W(2)) u_sync (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_pins({I_SCL, I_SDA}),
      .o_level({scl_s, sda_s})
   );

   // previous line levels for edge and condition detection
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         scl_d <= 1'h1;
         sda_d <= 1'h1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // bus conditions and clock edges
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
   assign byte_done = (bit_cnt_reg == BYTE_BITS);
   assign load_tx = scl_fall && ((state_reg == ST_ADDR_ACK && rw_reg) || state_reg == ST_TX_ACK);

   // byte returned to the host for the current pointer
   always_comb begin
      rd_byte = I_RAM_RDATA;
      case (ptr_reg)
         OFF_IRQ_ENABLE: rd_byte = irq_en_reg;
         OFF_IRQ_STATE: rd_byte = irq_state_reg;
         OFF_FIFO: rd_byte = I_FIFO.data;
         default: begin
            if (ptr_reg > OFF_DIRECT_LAST) begin
               rd_byte = READ_NONE;
            end
         end
      endcase
   end

   // slave bus sequencer: address match, receive, transmit and acknowledge
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= '0;
         shift_reg <= '0;
         ptr_reg <= '0;
         rw_reg <= 1'h0;
         first_reg <= 1'h0;
         long_hit_reg <= 1'h0;
         sda_oe_reg <= 1'h0;
         end_reg <= 1'h0;
         hw_we_reg <= 1'h0;
         hw_off_reg <= '0;
         hw_data_reg <= '0;
         hr_reg <= 1'h0;
         hr_off_reg <= '0;
      end else begin
         hw_we_reg <= 1'h0;
         hr_reg <= 1'h0;
         end_reg <= 1'h0;
         if (start_det) begin
            end_reg <= (state_reg != ST_IDLE);
            state_reg <= ST_ADDR;
            bit_cnt_reg <= '0;
            sda_oe_reg <= 1'h0;
         end else if (stop_det) begin
            end_reg <= (state_reg != ST_IDLE);
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'h0;
         end else if (scl_rise) begin
            case (state_reg)
               ST_ADDR, ST_ADDR2, ST_RX: begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               ST_TX_ACK: begin
                  if (sda_s) begin
                     state_reg <= ST_WAIT;
                  end
               end
               default: ;
            endcase
         end else if (load_tx) begin
            // data changes only right after a falling clock edge
            state_reg <= ST_TX;
            sda_oe_reg <= ~rd_byte[7];
            shift_reg <= {rd_byte[6:0], 1'h0};
            bit_cnt_reg <= 4'h1;
            hr_reg <= 1'h1;
            hr_off_reg <= ptr_reg;
            ptr_reg <= next_ptr(ptr_reg);
         end else if (scl_fall) begin
            case (state_reg)
               ST_ADDR: begin
                  if (byte_done) begin
                     if (I_CFG.long_address_select) begin
                        if (shift_reg[7:3] == LONG_PREAMBLE &&
                            shift_reg[2:1] == I_CFG.slave_bus_address[9:8] &&
                            (!shift_reg[0] || long_hit_reg)) begin
                           state_reg <= ST_ADDR_ACK;
                           sda_oe_reg <= 1'h1;
                           rw_reg <= shift_reg[0];
                        end else begin
                           state_reg <= ST_WAIT;
                           long_hit_reg <= 1'h0;
                        end
                     end else if (shift_reg[7:1] == I_CFG.slave_bus_address[6:0]) begin
                        state_reg <= ST_ADDR_ACK;
                        sda_oe_reg <= 1'h1;
                        rw_reg <= shift_reg[0];
                     end else begin
                        state_reg <= ST_WAIT;
                     end
                  end
               end
               ST_ADDR2: begin
                  if (byte_done) begin
                     if (shift_reg == I_CFG.slave_bus_address[7:0]) begin
                        state_reg <= ST_ADDR2_ACK;
                        sda_oe_reg <= 1'h1;
                        long_hit_reg <= 1'h1;
                     end else begin
                        state_reg <= ST_WAIT;
                        long_hit_reg <= 1'h0;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  sda_oe_reg <= 1'h0;
                  bit_cnt_reg <= '0;
                  first_reg <= 1'h1;
                  state_reg <= I_CFG.long_address_select ? ST_ADDR2 : ST_RX;
               end
               ST_ADDR2_ACK, ST_RX_ACK: begin
                  sda_oe_reg <= 1'h0;
                  bit_cnt_reg <= '0;
                  state_reg <= ST_RX;
               end
               ST_RX: begin
                  if (byte_done) begin
                     state_reg <= ST_RX_ACK;
                     sda_oe_reg <= 1'h1;
                     first_reg <= 1'h0;
                     if (first_reg) begin
                        ptr_reg <= shift_reg[6:0];
                     end else begin
                        hw_we_reg <= 1'h1;
                        hw_off_reg <= ptr_reg;
                        hw_data_reg <= shift_reg;
                        ptr_reg <= next_ptr(ptr_reg);
                     end
                  end
               end
               ST_TX: begin
                  if (byte_done) begin
                     state_reg <= ST_TX_ACK;
                     sda_oe_reg <= 1'h0;
                  end else begin
                     sda_oe_reg <= ~shift_reg[7];
                     shift_reg <= {shift_reg[6:0], 1'h0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
               ST_WAIT: sda_oe_reg <= 1'h0;
               default: ;
            endcase
         end
      end
   end

   // fifo read side effects: pop, underflow and read error
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         und_reg <= 1'h0;
         host_read_error_bit_reg <= 1'h0;
         pop_reg <= 1'h0;
      end else begin
         und_reg <= 1'h0;
         host_read_error_bit_reg <= 1'h0;
         pop_reg <= 1'h0;
         if (hr_reg && hr_off_reg == OFF_FIFO) begin
            if (I_FIFO.fifo_update_in_progress) begin
               host_read_error_bit_reg <= 1'h1;
            end else if (I_FIFO.fifo_valid_byte_count == '0) begin
               und_reg <= 1'h1;
            end else begin
               pop_reg <= 1'h1;
            end
         end
      end
   end

   // set and clear masks; every set source beats every clear
   always_comb begin
      set_v = '0;
      clr_v = '0;
      if (hw_we_reg && hw_off_reg == OFF_IRQ_SET) begin
         set_v = hw_data_reg;
      end
      if (hw_we_reg && hw_off_reg == OFF_IRQ_CLEAR) begin
         clr_v = hw_data_reg;
      end
      if (I_CPU_CTRL.write) begin
         set_v = set_v | I_CPU_CTRL.set;
         if (I_CPU_CTRL.clear_all) begin
            clr_v = IRQ_ALL;
         end
      end
      set_v[IRQ_BIT_UNDERFLOW] = set_v[IRQ_BIT_UNDERFLOW] | und_reg;
      set_v[IRQ_BIT_READ_ERROR] = set_v[IRQ_BIT_READ_ERROR] | host_read_error_bit_reg;
   end

   // host interrupt enables and state; only the host writes enables
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         irq_en_reg <= IRQ_RESET;
         irq_state_reg <= IRQ_RESET;
      end else begin
         if (hw_we_reg && hw_off_reg == OFF_IRQ_ENABLE) begin
            irq_en_reg <= hw_data_reg;
         end
         irq_state_reg <= (irq_state_reg & ~clr_v) | set_v;
      end
   end

   // merged host interrupt line and its pad
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         line_reg <= 1'h0;
         pad4_reg <= 1'h0;
         pad4_oe_reg <= 1'h0;
      end else begin
         line_reg <= |(irq_state_reg & irq_en_reg);
         pad4_reg <= I_CFG.pad4_host_irq & (|(irq_state_reg & irq_en_reg));
         pad4_oe_reg <= I_CFG.pad4_host_irq;
      end
   end

   // offsets touched in the current transfer, reported when it ends
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         t_dw_reg <= 1'h0;
         t_dr_reg <= 1'h0;
         t_fw_reg <= 1'h0;
         t_fr_reg <= 1'h0;
         done_reg <= '0;
      end else begin
         done_reg <= '0;
         if (end_reg) begin
            done_reg <= {t_dw_reg, t_dr_reg, t_fw_reg, t_fr_reg};
            t_dw_reg <= 1'h0;
            t_dr_reg <= 1'h0;
            t_fw_reg <= 1'h0;
            t_fr_reg <= 1'h0;
         end else begin
            // a burst may touch both spaces and then reports both
            if (hw_we_reg && hw_off_reg <= OFF_DIRECT_LAST) t_dw_reg <= 1'h1;
            if (hw_we_reg && hw_off_reg == OFF_FIFO) t_fw_reg <= 1'h1;
            if (hr_reg && hr_off_reg <= OFF_DIRECT_LAST) t_dr_reg <= 1'h1;
            if (hr_reg && hr_off_reg == OFF_FIFO) t_fr_reg <= 1'h1;
         end
      end
   end

   // flag sources for the CPU
   always_comb begin
      flag_set = '0;
      flag_set.host_irq_reg_write_flag = hw_we_reg && is_irq_off(hw_off_reg);
      flag_set.direct_write_done_flag = done_reg[3];
      flag_set.direct_read_done_flag = done_reg[2];
      flag_set.fifo_write_done_flag = done_reg[1];
      flag_set.fifo_read_done_flag = done_reg[0];
      flag_set.fifo_underflow_flag = und_reg;
      flag_set.fifo_read_error_flag = host_read_error_bit_reg;
   end

   // sticky CPU flags, write one to clear, a new event wins
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= (flags_reg & ~I_CPU_FLAG_CLR) | flag_set;
      end
   end

   // direct area port: write strobe or pointer for read data
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ram_reg <= '0;
      end else begin
         ram_reg.write <= hw_we_reg && (hw_off_reg <= OFF_DIRECT_LAST);
         ram_reg.addr <= hw_we_reg ? hw_off_reg : ptr_reg;
         ram_reg.wdata <= hw_data_reg;
      end
   end

   assign O_SDA = 1'h0; // open drain: only the enable moves
   assign O_SDA_OE = sda_oe_reg;
   assign O_RAM = ram_reg;
   assign O_FIFO_POP = pop_reg;
   assign O_HOST_IRQ_LINE = line_reg;
   assign O_PAD4 = pad4_reg;
   assign O_PAD4_OE = pad4_oe_reg;
   assign O_IRQ_ENABLE = irq_en_reg;
   assign O_IRQ_STATE = irq_state_reg;
   assign O_CPU_FLAGS = flags_reg;

   // checks on the guarded behaviour
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);

   property p_line;
      ##1 O_HOST_IRQ_LINE == |($past(irq_state_reg) & $past(irq_en_reg));
   endproperty
   a_line: assert property (p_line) else $error("host irq line mismatch");

   property p_pad4;
      ##1 O_PAD4 == (O_HOST_IRQ_LINE && $past(I_CFG.pad4_host_irq));
   endproperty
   a_pad4: assert property (p_pad4) else $error("pad4 not following irq");

   property p_underflow;
      und_reg |=> irq_state_reg[IRQ_BIT_UNDERFLOW] && flags_reg.fifo_underflow_flag;
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow not raised");

   property p_host_read_error_bit;
      hr_reg && hr_off_reg == OFF_FIFO && I_FIFO.fifo_update_in_progress
         |=> ##1 irq_state_reg[IRQ_BIT_READ_ERROR] && flags_reg.fifo_read_error_flag;
   endproperty
   a_host_read_error_bit: assert property (p_host_read_error_bit) else $error("read error not raised");

   property p_host_clear;
      (clr_v != '0) && (set_v == '0) |=> (irq_state_reg & $past(clr_v)) == '0;
   endproperty
   a_host_clear: assert property (p_host_clear) else $error("clear left bits");

   property p_cpu_set;
      I_CPU_CTRL.write |=> (irq_state_reg & $past(I_CPU_CTRL.set)) == $past(I_CPU_CTRL.set);
   endproperty
   a_cpu_set: assert property (p_cpu_set) else $error("cpu set lost");

   property p_en_ro;
      !(hw_we_reg && hw_off_reg == OFF_IRQ_ENABLE) |=> $stable(irq_en_reg);
   endproperty
   a_en_ro: assert property (p_en_ro) else $error("enable changed without host");

   property p_irq_write;
      hw_we_reg && is_irq_off(hw_off_reg) |=> flags_reg.host_irq_reg_write_flag;
   endproperty
   a_irq_write: assert property (p_irq_write) else $error("host write flag missing");

   property p_ack_hold;
      state_reg == ST_RX_ACK && $past(state_reg) == ST_RX_ACK |-> sda_oe_reg;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack not held low");

   property p_sda_low_clk;
      $changed(sda_oe_reg) && !$past(start_det || stop_det) |-> !$past(scl_s);
   endproperty
   a_sda_low_clk: assert property (p_sda_low_clk) else $error("sda moved with clk high");

   property p_stop;
      stop_det && !start_det |=> state_reg == ST_IDLE && !sda_oe_reg;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured");

   property p_restart;
      start_det && state_reg != ST_IDLE |=> end_reg ##1 state_reg != ST_IDLE;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not ending transfer");

   c_write_done: cover property (flags_reg.direct_write_done_flag);
   c_read_done: cover property (done_reg[0] && done_reg[2]);
   c_underflow: cover property (und_reg);
   c_pad4: cover property (O_PAD4);

endmodule

// ### host_irq_link_pkg.sv
// shared constants, states and carrier types of the host interrupt link
package host_irq_link_pkg;

   // system clock and the fastest link rate the slave must follow
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned LINK_MAX_HZ = 1_000_000;
   localparam int unsigned LINK_MIN_PERIOD_NS = 1000;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int unsigned LINK_MIN_PERIOD_CYC = LINK_MIN_PERIOD_NS / CLK_PERIOD_NS;

   // host offsets of the hardware functions
   localparam logic [6:0] OFF_DIRECT_LAST = 7'h77;
   localparam logic [6:0] OFF_IRQ_ENABLE = 7'h78;
   localparam logic [6:0] OFF_IRQ_STATE = 7'h79;
   localparam logic [6:0] OFF_IRQ_CLEAR = 7'h7a;
   localparam logic [6:0] OFF_IRQ_SET = 7'h7b;
   localparam logic [6:0] OFF_FIFO = 7'h7f;

   // host interrupt field layout and reset values
   localparam int unsigned IRQ_BIT_UNDERFLOW = 7;
   localparam int unsigned IRQ_BIT_READ_ERROR = 6;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [7:0] IRQ_ALL = 8'hff;
   localparam logic [7:0] READ_NONE = 8'h00;

   // two-wire framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [4:0] LONG_PREAMBLE = 5'h1e;

   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_ADDR2, ST_ADDR2_ACK,
      ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT
   } link_state_t;

   typedef struct packed {
      logic write;
      logic clear_all;
      logic [7:0] set;
   } cpu_host_irq_control_t;

   typedef struct packed {
      logic host_irq_reg_write_flag;
      logic direct_write_done_flag;
      logic direct_read_done_flag;
      logic fifo_write_done_flag;
      logic fifo_read_done_flag;
      logic fifo_underflow_flag;
      logic fifo_read_error_flag;
   } cpu_flag_status_t;

   typedef struct packed {
      logic long_address_select;
      logic [9:0] slave_bus_address;
      logic pad4_host_irq;
   } link_cfg_t;

   typedef struct packed {
      logic fifo_update_in_progress;
      logic [9:0] fifo_valid_byte_count;
      logic [7:0] data;
   } fifo_side_t;

   typedef struct packed {
      logic write;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ram_req_t;

endpackage

// ### link_pin_sync.sv
// three-stage pin synchroniser that accepts a level once two stages agree
module link_pin_sync #(
   parameter int unsigned W = 2
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_pins,
   output logic [W-1:0] o_level
);

   logic [W-1:0] ff1_reg;
   logic [W-1:0] ff2_reg;
   logic [W-1:0] ff3_reg;
   logic [W-1:0] level_reg;

   // idle bus lines are high, so every stage resets high
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff1_reg <= '1;
         ff2_reg <= '1;
         ff3_reg <= '1;
         level_reg <= '1;
      end else begin
         ff1_reg <= i_pins;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         for (int i = 0; i < W; i++) begin
            if (ff2_reg[i] == ff3_reg[i]) begin
               level_reg[i] <= ff3_reg[i];
            end
         end
      end
   end

   assign o_level = level_reg;

endmodule

// ### host_master_model.sv
// two-wire bus master model standing in for the host processor
module host_master_model
   import host_irq_link_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_oe,
   output logic o_scl,
   output logic o_sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv = 1'b1;
   // open-drain wire: pull-up unless someone pulls low
   assign o_sda = drv & ~i_oe;
   initial o_scl = 1'b1;
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // one bit of 80 ns: data moves only while the clock is low
   task automatic bit_x(input logic b, output logic s);
      o_scl <= 1'b0;
      tick(3);
      drv <= b;
      tick(3);
      o_scl <= 1'b1;
      tick(2);
      s = o_sda;
   endtask
   // start from an idle or released bus, so a repeat start is also legal
   task automatic start();
      o_scl <= 1'b0;
      tick(3);
      drv <= 1'b1;
      tick(3);
      o_scl <= 1'b1;
      tick(4);
      drv <= 1'b0;
      tick(4);
   endtask
   task automatic stop();
      o_scl <= 1'b0;
      tick(3);
      drv <= 1'b0;
      tick(3);
      o_scl <= 1'b1;
      tick(4);
      drv <= 1'b1;
      tick(8);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], s);
      end
      bit_x(1'b1, s);
      ack = ~s;
   endtask
   // the last byte read is left unacknowledged
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(last, s);
   endtask
endmodule

// ### host_slave_irq_and_link_bench.sv
// self-checking bench of the host interrupt exchange over the two-wire link
module host_slave_irq_and_link_bench
   import host_irq_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, scl, sda, oe, pop, line, pad4, pad4_oe, a;
   link_cfg_t cfg;
   cpu_host_irq_control_t ctrl;
   cpu_flag_status_t fclr, flags;
   fifo_side_t fifo;
   ram_req_t ram, ram_seen;
   logic [7:0] en, st, e, s, c, m, d, rdata;
   integer seed = 8;
   int err_total = 0;
   int cmp_count = 0;
   int pops = 0;
   // direct area contents seen by the host: a fixed pattern of the offset
   function automatic logic [7:0] ram_byte(input logic [6:0] a);
      return {a, 1'b1} ^ 8'h5c;
   endfunction
   assign rdata = ram_byte(ram.addr);
   host_irq_link host_irq_link_inst (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SCL(scl),
      .I_SDA(sda), .O_SDA(), .O_SDA_OE(oe), .I_CFG(cfg), .I_CPU_CTRL(ctrl),
      .I_CPU_FLAG_CLR(fclr), .I_FIFO(fifo), .I_RAM_RDATA(rdata), .O_RAM(ram),
      .O_FIFO_POP(pop), .O_HOST_IRQ_LINE(line), .O_PAD4(pad4), .O_PAD4_OE(pad4_oe),
      .O_IRQ_ENABLE(en), .O_IRQ_STATE(st), .O_CPU_FLAGS(flags));
   host_master_model host_master_model_inst (.i_clk(clk), .i_oe(oe), .o_scl(scl), .o_sda(sda));
   // catch the one-cycle direct area write pulse
   always @(posedge clk) begin
      if (ram.write === 1'b1) begin
         ram_seen <= ram;
      end
      if (pop === 1'b1) begin
         pops <= pops + 1;
      end
   end
   task automatic end_of_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // host write burst: address, offset, then data bytes
   task automatic hw(input logic [7:0] off, input logic [7:0] q[$]);
      host_master_model_inst.start();
      host_master_model_inst.wbyte(8'ha4, a);
      chk("addr ack", a, 1'b1);
      host_master_model_inst.wbyte(off, a);
      foreach (q[i]) begin
         host_master_model_inst.wbyte(q[i], a);
         chk("data ack", a, 1'b1);
      end
      host_master_model_inst.stop();
      repeat (6) @(posedge clk);
   endtask
   // offset write, repeat start, one byte read back
   task automatic hr(input logic [7:0] off, output logic [7:0] v);
      host_master_model_inst.start();
      host_master_model_inst.wbyte(8'ha4, a);
      host_master_model_inst.wbyte(off, a);
      host_master_model_inst.start();
      host_master_model_inst.wbyte(8'ha5, a);
      chk("read ack", a, 1'b1);
      host_master_model_inst.rbyte(1'b1, v);
      host_master_model_inst.stop();
      repeat (6) @(posedge clk);
   endtask
   task automatic clr_flags();
      fclr <= '1;
      @(posedge clk);
      fclr <= '0;
      @(posedge clk);
   endtask
   task automatic cpu(input logic all, input logic [7:0] v);
      ctrl <= '{write: 1'b1, clear_all: all, set: v};
      @(posedge clk);
      ctrl <= '0;
      repeat (3) @(posedge clk);
   endtask
   task automatic line_chk();
      chk("line", line, |(s & e));
      chk("pad4", pad4, |(s & e));
      chk("pad4 oe", pad4_oe, 1'b1);
      chk("state", st, s);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #400us;
      err_total++;
      end_of_test();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      cfg = '{long_address_select: 1'b0, slave_bus_address: 10'h052, pad4_host_irq: 1'b1};
      ctrl = '0;
      fclr = '0;
      fifo = '0;
      ram_seen = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk("enable reset", en, 8'h00);
      chk("flags reset", flags, 7'h00);
      e = 8'($random(seed));
      s = 8'($random(seed));
      c = 8'($random(seed));
      m = 8'($random(seed));
      // burst from the last direct offset across all four interrupt offsets
      hw(8'h77, '{8'h3c, e, 8'h99, 8'h00, s});
      chk("enable", en, e);
      chk("ram addr", ram_seen.addr, 7'h77);
      chk("ram data", ram_seen.wdata, 8'h3c);
      chk("flags", flags, 7'h60);
      line_chk();
      clr_flags();
      // clear-only write still flags the cpu
      hw(8'h7a, '{c});
      s = s & ~c;
      line_chk();
      chk("flags", flags, 7'h40);
      hr(8'h79, d);
      chk("host read state", d, s);
      cpu(1'b0, m);
      s = s | m;
      line_chk();
      cpu(1'b1, 8'h00);
      s = 8'h00;
      line_chk();
      clr_flags();
      // empty fifo read
      hr(8'h7f, d);
      chk("flags", flags, 7'h06);
      chk("bit7", st, 8'h80);
      chk("empty data", d, 8'h00);
      cpu(1'b1, 8'h00);
      clr_flags();
      // fifo read while the cpu rearranges it
      fifo <= '{fifo_update_in_progress: 1'b1, fifo_valid_byte_count: 10'h005, data: 8'h5a};
      hr(8'h7f, d);
      chk("flags", flags, 7'h05);
      chk("bit6", st, 8'h40);
      chk("fifo data", d, 8'h5a);
      clr_flags();
      // fifo read with bytes waiting pops exactly one
      fifo <= '{fifo_update_in_progress: 1'b0, fifo_valid_byte_count: 10'h005, data: 8'h3e};
      hr(8'h7f, d);
      chk("fifo byte", d, 8'h3e);
      chk("flags", flags, 7'h04);
      chk("pops", pops, 1);
      clr_flags();
      // direct area read back
      hr(8'h20, d);
      chk("ram byte", d, ram_byte(7'h20));
      chk("flags", flags, 7'h10);
      // wrong slave address gets no acknowledge
      host_master_model_inst.start();
      host_master_model_inst.wbyte(8'ha6, a);
      chk("foreign ack", a, 1'b0);
      host_master_model_inst.stop();
      // long addressing: preamble with upper bits, then the lower byte
      cfg.long_address_select <= 1'b1;
      host_master_model_inst.start();
      host_master_model_inst.wbyte(8'hf0, a);
      chk("long ack 1", a, 1'b1);
      host_master_model_inst.wbyte(8'h52, a);
      chk("long ack 2", a, 1'b1);
      host_master_model_inst.wbyte(8'h7b, a);
      host_master_model_inst.wbyte(m, a);
      host_master_model_inst.stop();
      repeat (6) @(posedge clk);
      chk("long set", st, 8'h40 | m);
      chk("flags", flags, 7'h50);
      end_of_test();
   end
endmodule
